// >>> src/edge_if.sv
// Level in, edge pulses out, between the channel and its edge detectors.
// Assumes all levels are synchronous to the system clock.
`default_nettype none
interface edge_if;
	logic sig;
	logic [1:0] code;
	logic rise;
	logic fall;
	logic hit;
	modport sense(input sig, input code, output rise, output fall, output hit);
	modport user(output sig, output code, input rise, input fall, input hit);
endinterface
`default_nettype wire

// >>> src/edge_sense.sv
// Edge detector; code 01 rising, 10 falling, 11 either, 00 none.
// Assumes the level is synchronous to clk_sys_i.
`default_nettype none
module edge_sense (
	// Clock and control
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Level and edges
	edge_if.sense e
);
	typedef struct packed {
		logic prev;
	} edge_state_t;
	edge_state_t s;
	edge_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.prev = e.sig;
	end

	assign e.rise = e.sig & ~s.prev;
	assign e.fall = ~e.sig & s.prev;
	assign e.hit = (e.code[0] & e.rise) | (e.code[1] & e.fall);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// >>> src/line_action.sv
// Next level of an output line from four events and their two-bit actions.
// Events by rising priority: match, compare C, external event, software trigger.
`default_nettype none
module line_action (
	// Present level
	input wire logic level_i,
	// Actions {sw, event, match c, match}
	input wire logic [7:0] act_i,
	input wire logic [3:0] ev_i,
	// Result
	output logic next_o
);
	always_comb begin
		next_o = level_i;
		for (int i = 0; i < 4; i++) begin
			if (ev_i[i]) begin
				case (act_i[2*i +: 2])
					2'b01: next_o = 1'b1;
					2'b10: next_o = 1'b0;
					2'b11: next_o = ~level_i;
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> src/timer_channel_regs.sv
// Three-channel 16-bit timer with Avalon-MM register access.
// Assumes ticks, pins and external clocks are synchronous to clk_sys_i.
//
// Contract
// R1: Channel registers repeat every 0x40; block registers at 0xC0 and 0xC4.
// R2: Block control bit 0 written one triggers all three channels together.
// R3: Aux line 0 takes ext clock 0, nothing, channel 1 A, channel 2 A.
// R4: Aux line 1 takes ext clock 1, nothing, channel 0 A, channel 2 A.
// R5: Aux line 2 takes ext clock 2, nothing, channel 0 A, channel 1 A.
// R6: Control bit 0 enables counter clock unless bit 1 also written one.
// R7: Control bit 1 written one disables the counter clock.
// R8: Control bit 2 written one resets counter and starts its clock; in up-down shapes the code reverses the count direction instead of resetting.
// R9: Clock select codes 0-4 pick ticks 1-5, codes 5-7 aux lines.
// R10: Clock invert bit picks rising edge at zero, falling at one.
// R11: Gate field ANDs selected clock with aux line 0, 1 or 2.
// R12: Capture mode, bit 6 stops counter clock when B loads.
// R13: Capture mode, bit 7 disables counter clock when B loads.
// R14: Capture trigger edge field 9:8: none, rising, falling, both.
// R15: Capture bit 10 takes trigger from line B at zero, A at one.
// R16: Capture bit 14 lets compare C match reset and start the counter.
// R17: Mode bit 15 chooses capture at zero, waveform at one.
// R18: Load-A field 17:16 picks A-line edge loading value A.
// R19: Load-B field 19:18 picks A-line edge loading value B.
// R20: Values A and B writable only in waveform; C always; count never.
// R21: Waveform fields: disable 7, stop 6, edge 9:8, source 11:10, trigger 12, shape 14:13.
// R22: Bits 31:16 hold eight two-bit line action fields.
// R23: Action codes: none, set high, set low, invert.
// R24: Shape: up, up-down, up with C trigger, up-down to C.
// R25: Event trigger enable lets the external event reset and start the counter; in up-down shapes the code reverses the count direction instead of resetting.
// R26: Waveform compare C stop and disable bits halt the counter clock.
// R27: Enable register sets mask bits, disable clears them, mask reads back.
//
// The Avalon-MM interface to the registers was left to the implementer.
`default_nettype none
module timer_channel_regs
	import timer_pkg::*;
(
	// Clock, reset, clock enable
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Internal ticks 1 to 5 and external clocks
	input wire logic [4:0] tick_i,
	input wire logic [timer_pkg::NUM_CH-1:0] ext_clock_in_i,
	// Timer lines
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_a_i,
	output logic [timer_pkg::NUM_CH-1:0] io_line_a_o,
	output logic [timer_pkg::NUM_CH-1:0] io_line_a_oe_o,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_b_i,
	output logic [timer_pkg::NUM_CH-1:0] io_line_b_o,
	output logic [timer_pkg::NUM_CH-1:0] io_line_b_oe_o
);
	import timer_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] mode;
		logic [COUNT_W-1:0] count;
		logic [COUNT_W-1:0] va;
		logic [COUNT_W-1:0] vb;
		logic [COUNT_W-1:0] vc;
		logic [7:0] flags;
		logic [7:0] mask;
		logic enabled;
		logic running;
		logic down;
		logic a_done;
		logic a_unread;
		logic b_unread;
		logic out_a;
		logic out_b;
	} chan_t;

	typedef struct packed {
		chan_t [NUM_CH-1:0] ch;
		logic [BMODE_W-1:0] bmode;
		logic [31:0] rdata;
		logic ack;
	} top_state_t;

	top_state_t s;
	top_state_t next_s;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	logic [1:0] bus_ch;
	logic [5:0] bus_off;
	logic ch_sel;
	logic wr_now;
	logic rd_cap;
	logic sync_cmd;
	logic [31:0] wd_m;

	assign bus_ch = avs_address_i[7:6];
	assign bus_off = avs_address_i[5:0];
	// R1: channel stride decode
	assign ch_sel = (bus_ch < 2'(NUM_CH));
	assign wr_now = avs_write_i & s.ack;
	assign rd_cap = avs_read_i & ~s.ack;
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s.ack;
	assign avs_readdata_o = s.rdata;
	// R2: all-channel trigger
	assign sync_cmd = wr_now & (avs_address_i == OFF_BCTRL) & avs_byteenable_i[0] & avs_writedata_i[B_SYNC];

	// ****************************************
	// Aux clock lines
	// ****************************************
	logic [NUM_CH-1:0] aux;
	logic [3:0] aux_src [NUM_CH];

	// R3: aux line 0 sources
	assign aux_src[0] = {io_line_a_i[2], io_line_a_i[1], 1'b0, ext_clock_in_i[0]};
	// R4: aux line 1 sources
	assign aux_src[1] = {io_line_a_i[2], io_line_a_i[0], 1'b0, ext_clock_in_i[1]};
	// R5: aux line 2 sources
	assign aux_src[2] = {io_line_a_i[1], io_line_a_i[0], 1'b0, ext_clock_in_i[2]};

	// ****************************************
	// Per-channel edges and events
	// ****************************************
	logic [NUM_CH-1:0] tick;
	logic [NUM_CH-1:0] a_rise;
	logic [NUM_CH-1:0] a_fall;
	logic [NUM_CH-1:0] ev_hit;
	logic [NUM_CH-1:0] sw_trig;
	logic [NUM_CH-1:0] ctl_wr;
	logic [NUM_CH-1:0] cmp_a;
	logic [NUM_CH-1:0] cmp_b;
	logic [NUM_CH-1:0] cmp_c;
	logic [NUM_CH-1:0] nxt_a;
	logic [NUM_CH-1:0] nxt_b;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		edge_if ck();
		edge_if la();
		edge_if ev();
		logic [31:0] m;
		logic [7:0] srcs;
		logic [3:0] gates;
		logic [3:0] evsrcs;
		logic wave;

		assign m = s.ch[c].mode;
		// R17: mode select
		assign wave = m[M_WAVE];
		assign aux[c] = aux_src[c][s.bmode[2*c +: 2]];
		// R9: clock source
		assign srcs = {aux, tick_i};
		// R11: burst gating
		assign gates = {aux, 1'b1};
		assign ck.sig = srcs[m[F_CLKSEL +: 3]] & gates[m[F_BURST +: 2]];
		// R10: active edge
		assign ck.code = m[M_CLOCK_INVERT] ? 2'b10 : 2'b01;
		assign la.sig = io_line_a_i[c];
		assign la.code = 2'b11;
		// R15: capture trigger input
		// R21: waveform event source
		assign evsrcs = {aux, io_line_b_i[c]};
		assign ev.sig = wave ? evsrcs[m[F_EVSRC +: 2]] : (m[M_ABSEL] ? io_line_a_i[c] : io_line_b_i[c]);
		// R14: trigger edge
		assign ev.code = m[F_EDGE +: 2];

		edge_sense u_ck (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .e(ck));
		edge_sense u_la (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .e(la));
		edge_sense u_ev (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .e(ev));

		assign tick[c] = ck.hit & s.ch[c].enabled & s.ch[c].running;
		assign a_rise[c] = la.rise;
		assign a_fall[c] = la.fall;
		assign ev_hit[c] = ev.hit;
		assign ctl_wr[c] = wr_now & ch_sel & (bus_ch == 2'(c)) & (bus_off == OFF_CTRL) & avs_byteenable_i[0];
		// R8: software trigger
		assign sw_trig[c] = sync_cmd | (ctl_wr[c] & avs_writedata_i[B_SOFTWARE_TRIGGER_CMD]);
		assign cmp_a[c] = tick[c] & wave & (s.ch[c].count == s.ch[c].va);
		assign cmp_b[c] = tick[c] & wave & (s.ch[c].count == s.ch[c].vb);
		assign cmp_c[c] = tick[c] & (s.ch[c].count == s.ch[c].vc);

		// R22: line A actions in 23:16, B in 31:24
		// R23: action coding
		line_action u_act_a (
			.level_i(s.ch[c].out_a),
			.act_i(m[F_ACT_A +: 8]),
			.ev_i({sw_trig[c], ev_hit[c], cmp_c[c], cmp_a[c]}),
			.next_o(nxt_a[c])
		);
		line_action u_act_b (
			.level_i(s.ch[c].out_b),
			.act_i(m[F_ACT_B +: 8]),
			.ev_i({sw_trig[c], ev_hit[c], cmp_c[c], cmp_b[c]}),
			.next_o(nxt_b[c])
		);

		assign io_line_a_o[c] = s.ch[c].out_a;
		assign io_line_a_oe_o[c] = wave;
		assign io_line_b_o[c] = s.ch[c].out_b;
		assign io_line_b_oe_o[c] = wave & (m[F_EVSRC +: 2] != 2'b00);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		chan_t x;
		logic wave;
		logic updown;
		logic trig;
		logic lda;
		logic ldb;
		logic hit;
		logic [COUNT_W-1:0] top;
		logic [31:0] rd;
		x = '0;
		wave = 1'b0;
		updown = 1'b0;
		trig = 1'b0;
		lda = 1'b0;
		ldb = 1'b0;
		hit = 1'b0;
		top = '0;
		rd = '0;
		next_s = s;
		next_s.ack = (avs_read_i | avs_write_i) & ~s.ack;
		if (wr_now & (avs_address_i == OFF_BMODE)) begin
			next_s.bmode = BMODE_W'(be_merge(32'(s.bmode), avs_writedata_i, avs_byteenable_i));
		end
		if (avs_address_i == OFF_BMODE) begin
			rd = 32'(s.bmode);
		end
		for (int c = 0; c < NUM_CH; c++) begin
			x = s.ch[c];
			hit = ch_sel & (bus_ch == 2'(c));
			wd_m = be_merge(32'(0), avs_writedata_i, avs_byteenable_i);
			// Read side effects at capture, before hardware sets
			if (hit) begin
				case (bus_off)
					OFF_MODE: rd = x.mode;
					OFF_COUNT: rd = 32'(x.count);
					OFF_VA: rd = 32'(x.va);
					OFF_VB: rd = 32'(x.vb);
					OFF_VC: rd = 32'(x.vc);
					OFF_STAT: rd = {13'h0, io_line_b_i[c], io_line_a_i[c], x.enabled, 8'h0, x.flags};
					OFF_IMASK: rd = 32'(x.mask);
					default: rd = rd;
				endcase
				if (rd_cap) begin
					if (bus_off == OFF_STAT) begin
						x.flags = '0;
					end
					if (bus_off == OFF_VA) begin
						x.a_unread = 1'b0;
					end
					if (bus_off == OFF_VB) begin
						x.b_unread = 1'b0;
					end
				end
			end
			if (hit & wr_now) begin
				case (bus_off)
					OFF_MODE: x.mode = be_merge(x.mode, avs_writedata_i, avs_byteenable_i);
					// R20: A and B writable in waveform only
					OFF_VA: if (x.mode[M_WAVE]) x.va = COUNT_W'(be_merge(32'(x.va), avs_writedata_i, avs_byteenable_i));
					OFF_VB: if (x.mode[M_WAVE]) x.vb = COUNT_W'(be_merge(32'(x.vb), avs_writedata_i, avs_byteenable_i));
					OFF_VC: x.vc = COUNT_W'(be_merge(32'(x.vc), avs_writedata_i, avs_byteenable_i));
					// R27: mask set and clear
					OFF_IEN: x.mask = x.mask | wd_m[7:0];
					OFF_IDIS: x.mask = x.mask & ~wd_m[7:0];
					default: ;
				endcase
			end
			wave = s.ch[c].mode[M_WAVE];
			// R24: shape select
			updown = wave & s.ch[c].mode[M_UPDOWN];
			// R16: compare C trigger
			// R25: event trigger enable
			trig = sw_trig[c] | (ev_hit[c] & (~wave | s.ch[c].mode[M_ETRG]))
				| (cmp_c[c] & s.ch[c].mode[M_CTRG] & ~updown);
			if (ev_hit[c] & (~wave | s.ch[c].mode[M_ETRG])) begin
				x.flags[S_ETRG] = 1'b1;
			end
			// Counting
			if (tick[c]) begin
				if (s.ch[c].count == COUNT_MAX) begin
					x.flags[S_COVF] = 1'b1;
				end
				top = s.ch[c].mode[M_CTRG] ? s.ch[c].vc : COUNT_MAX;
				if (!updown) begin
					x.count = s.ch[c].count + 1'b1;
				end else if (!s.ch[c].down) begin
					x.down = (s.ch[c].count == top);
					x.count = x.down ? s.ch[c].count - 1'b1 : s.ch[c].count + 1'b1;
				end else begin
					x.down = (s.ch[c].count != '0);
					x.count = x.down ? s.ch[c].count - 1'b1 : s.ch[c].count + 1'b1;
				end
			end
			if (cmp_a[c]) begin
				x.flags[S_CPA] = 1'b1;
			end
			if (cmp_b[c]) begin
				x.flags[S_CPB] = 1'b1;
			end
			if (cmp_c[c]) begin
				x.flags[S_CPC] = 1'b1;
				// R26: stop and disable on C
				if (wave & s.ch[c].mode[M_STOP]) begin
					x.running = 1'b0;
				end
				if (wave & s.ch[c].mode[M_DIS]) begin
					x.enabled = 1'b0;
				end
			end
			// R18: load A edge
			lda = ~wave & ((s.ch[c].mode[F_LDA] & a_rise[c]) | (s.ch[c].mode[F_LDA+1] & a_fall[c]));
			// R19: load B edge
			ldb = ~wave & ((s.ch[c].mode[F_LDB] & a_rise[c]) | (s.ch[c].mode[F_LDB+1] & a_fall[c]));
			if (lda & ~s.ch[c].a_done) begin
				x.va = s.ch[c].count;
				x.a_done = 1'b1;
				x.flags[S_LDA] = 1'b1;
				x.flags[S_LOVR] = x.flags[S_LOVR] | s.ch[c].a_unread;
				x.a_unread = 1'b1;
			end else if (ldb & s.ch[c].a_done) begin
				x.vb = s.ch[c].count;
				x.a_done = 1'b0;
				x.flags[S_LDB] = 1'b1;
				x.flags[S_LOVR] = x.flags[S_LOVR] | s.ch[c].b_unread;
				x.b_unread = 1'b1;
				// R12: stop on B load
				if (s.ch[c].mode[M_STOP]) begin
					x.running = 1'b0;
				end
				// R13: disable on B load
				if (s.ch[c].mode[M_DIS]) begin
					x.enabled = 1'b0;
				end
			end
			if (trig) begin
				// R26: stop outlasts auto trigger
				x.running = ~(cmp_c[c] & wave & s.ch[c].mode[M_STOP]) | sw_trig[c];
				x.a_done = 1'b0;
				if (updown) begin
					x.down = ~s.ch[c].down;
				end else begin
					x.count = '0;
					x.down = 1'b0;
				end
			end
			// R7: disable command
			if (ctl_wr[c] & avs_writedata_i[B_CLOCK_DISABLE_CMD]) begin
				x.enabled = 1'b0;
			// R6: enable command
			end else if (ctl_wr[c] & avs_writedata_i[B_CLOCK_ENABLE_CMD]) begin
				x.enabled = 1'b1;
			end
			// R21: waveform drives the lines
			if (wave) begin
				x.out_a = nxt_a[c];
				if (s.ch[c].mode[F_EVSRC +: 2] != 2'b00) begin
					x.out_b = nxt_b[c];
				end
			end
			next_s.ch[c] = x;
		end
		if (rd_cap) begin
			next_s.rdata = rd;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// >>> src/timer_pkg.sv
// Constants for the three-channel timer block.
// Assumes a 32-bit bus with byte addressing.
`default_nettype none
package timer_pkg;
	localparam int NUM_CH = 3;
	localparam int COUNT_W = 16;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_BCTRL = 8'hc0;
	localparam logic [7:0] OFF_BMODE = 8'hc4;
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_MODE = 6'h04;
	localparam logic [5:0] OFF_COUNT = 6'h10;
	localparam logic [5:0] OFF_VA = 6'h14;
	localparam logic [5:0] OFF_VB = 6'h18;
	localparam logic [5:0] OFF_VC = 6'h1c;
	localparam logic [5:0] OFF_STAT = 6'h20;
	localparam logic [5:0] OFF_IEN = 6'h24;
	localparam logic [5:0] OFF_IDIS = 6'h28;
	localparam logic [5:0] OFF_IMASK = 6'h2c;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int B_CLOCK_ENABLE_CMD = 0;
	localparam int B_CLOCK_DISABLE_CMD = 1;
	localparam int B_SOFTWARE_TRIGGER_CMD = 2;
	localparam int B_SYNC = 0;
	localparam int F_CLKSEL = 0;
	localparam int M_CLOCK_INVERT = 3;
	localparam int F_BURST = 4;
	localparam int M_STOP = 6;
	localparam int M_DIS = 7;
	localparam int F_EDGE = 8;
	localparam int M_ABSEL = 10;
	localparam int F_EVSRC = 10;
	localparam int M_ETRG = 12;
	localparam int M_UPDOWN = 13;
	localparam int M_CTRG = 14;
	localparam int M_WAVE = 15;
	localparam int F_LDA = 16;
	localparam int F_LDB = 18;
	localparam int F_ACT_A = 16;
	localparam int F_ACT_B = 24;
	localparam int BMODE_W = 6;
	localparam int S_COVF = 0;
	localparam int S_LOVR = 1;
	localparam int S_CPA = 2;
	localparam int S_CPB = 3;
	localparam int S_CPC = 4;
	localparam int S_LDA = 5;
	localparam int S_LDB = 6;
	localparam int S_ETRG = 7;
	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [31:0] MODE_RST = 32'h0;
	localparam logic [5:0] BMODE_RST = 6'h0;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage
`default_nettype wire

// >>> verif/timer_channel_regs_properties.sv
// Bus and pin-direction checks for the timer block, bound to its top.
// Assumes the top module's ports only; one clock domain.
`default_nettype none
module timer_channel_regs_properties
	import timer_pkg::*;
(
	// Clock, reset, bus
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Pins
	input wire logic [4:0] tick_i,
	input wire logic [timer_pkg::NUM_CH-1:0] ext_clock_in_i,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_a_i,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_a_o,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_a_oe_o,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_b_i,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_b_o,
	input wire logic [timer_pkg::NUM_CH-1:0] io_line_b_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic req;
	logic rdone;
	logic [5:0] off;
	assign req = avs_read_i || avs_write_i;
	assign rdone = avs_read_i && !avs_waitrequest_o;
	assign off = avs_address_i[5:0];
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// ****************************************
	// Assertions
	// ****************************************
	a_idle_no_wait: assert property (!req |-> !avs_waitrequest_o)
		else $error("waitrequest high while idle");
	a_first_cycle_wait: assert property (ce_i && req && !$past(req) |-> avs_waitrequest_o)
		else $error("request answered without wait");
	a_single_wait: assert property (ce_i && req && avs_waitrequest_o |=> !req || !avs_waitrequest_o)
		else $error("wait longer than one cycle");
	a_write_only_zero: assert property (rdone && (off == OFF_CTRL || off == OFF_IEN || off == OFF_IDIS
		|| off == 6'h08 || off == 6'h0c) |-> avs_readdata_o == 32'h0)
		else $error("write-only or reserved read not zero");
	a_mask_width: assert property (rdone && off == OFF_IMASK |-> avs_readdata_o[31:8] == 24'h0)
		else $error("mask upper bits set");
	a_bmode_width: assert property (rdone && avs_address_i == OFF_BMODE |-> avs_readdata_o[31:6] == 26'h0)
		else $error("block mode upper bits set");
	a_value_width: assert property (rdone && (off == OFF_COUNT || off == OFF_VA || off == OFF_VB
		|| off == OFF_VC) |-> avs_readdata_o[31:16] == 16'h0)
		else $error("value register upper bits set");
	a_oe_after_reset: assert property ($fell(reset_i) |-> io_line_a_oe_o == 3'h0 && io_line_b_oe_o == 3'h0)
		else $error("line driven right after reset");
	a_b_needs_wave: assert property ((io_line_b_oe_o & ~io_line_a_oe_o) == 3'h0)
		else $error("line B driven outside waveform mode");
endmodule
bind timer_channel_regs timer_channel_regs_properties i_props (.clk_sys_i, .reset_i, .ce_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.tick_i, .ext_clock_in_i, .io_line_a_i, .io_line_a_o, .io_line_a_oe_o, .io_line_b_i, .io_line_b_o,
	.io_line_b_oe_o);
`default_nettype wire

// >>> verif/timer_channel_regs_tb.sv
// Register-level testbench for the timer block.
// Assumes the pin model on the far side and the bound checker.
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module timer_channel_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_pkg::*;
	logic clk_sys_i, reset_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, ext_run;
	logic [7:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q, q1;
	logic [3:0] avs_byteenable_i;
	logic [4:0] tick_i;
	logic [NUM_CH-1:0] ext_clock_in_i, io_line_a_i, io_line_a_o, io_line_a_oe_o;
	logic [NUM_CH-1:0] io_line_b_i, io_line_b_o, io_line_b_oe_o;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	localparam logic [5:0] RST_OFF [6] = '{OFF_MODE, OFF_COUNT, OFF_VA, OFF_VB, OFF_VC, OFF_IMASK};
	localparam logic [1:0] ACT [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	localparam logic LVL [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	timer_channel_regs i_dut (.clk_sys_i, .reset_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .tick_i, .ext_clock_in_i,
		.io_line_a_i, .io_line_a_o, .io_line_a_oe_o, .io_line_b_i, .io_line_b_o, .io_line_b_oe_o);
	timer_pins_model i_pins (.clk_sys_i, .ext_run_i(ext_run), .a_o_i(io_line_a_o), .a_oe_i(io_line_a_oe_o),
		.b_o_i(io_line_b_o), .b_oe_i(io_line_b_oe_o), .tick_o(tick_i), .ext_o(ext_clock_in_i),
		.a_o(io_line_a_i), .b_o(io_line_b_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	// ****************************************
	// Bus access
	// ****************************************
	function automatic logic [7:0] ad(input int c, input logic [5:0] o);
		return {c[1:0], o};
	endfunction
	// Hold the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= rd;
		avs_write_i <= !rd;
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_o !== 1'b0);
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b0, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b1, a, 32'h0, q);
		`CHK($sformatf("reg %h", a), e, q)
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			stop_test();
		end
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		reset_i = 1'b1;
		ce_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 8'h00;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hf;
		ext_run = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		for (int c = 0; c < 3; c++) foreach (RST_OFF[i]) rdc(ad(c, RST_OFF[i]), 32'h0);
		rdc(OFF_BMODE, 32'h0);
		for (int c = 0; c < 3; c++) wr(ad(c, OFF_MODE), 32'h4038 | c);
		for (int c = 0; c < 3; c++) rdc(ad(c, OFF_MODE), 32'h4038 | c);
		rdc(ad(1, 6'h08), 32'h0);
		rdc(ad(0, OFF_CTRL), 32'h0);
		rdc(8'he0, 32'h0);
		wr(OFF_BMODE, 32'hffff_ff2d);
		rdc(OFF_BMODE, 32'h2d);
		for (int c = 0; c < 3; c++) begin
			wr(ad(c, OFF_IEN), 32'hffff_ffa5);
			wr(ad(c, OFF_IDIS), 32'h05);
			rdc(ad(c, OFF_IMASK), 32'ha0);
		end
		wr(ad(0, OFF_VA), 32'h1234);
		wr(ad(0, OFF_VB), 32'h5678);
		wr(ad(0, OFF_VC), 32'hbeef);
		wr(ad(0, OFF_COUNT), 32'h77);
		rdc(ad(0, OFF_VA), 32'h0);
		rdc(ad(0, OFF_VB), 32'h0);
		rdc(ad(0, OFF_VC), 32'hbeef);
		rdc(ad(0, OFF_COUNT), 32'h0);
		wr(ad(0, OFF_MODE), 32'h8000);
		wr(ad(0, OFF_VA), 32'h1234);
		rdc(ad(0, OFF_VA), 32'h1234);
		// Start, stop and trigger on channel 0
		wr(ad(0, OFF_MODE), 32'h0);
		wr(ad(0, OFF_CTRL), 32'h3);
		bus(1'b1, ad(0, OFF_STAT), 32'h0, q);
		`CHK("enabled", 1'b0, q[16])
		wr(ad(0, OFF_CTRL), 32'h1);
		bus(1'b1, ad(0, OFF_STAT), 32'h0, q);
		`CHK("enabled", 1'b1, q[16])
		rdc(ad(0, OFF_COUNT), 32'h0);
		wr(ad(0, OFF_CTRL), 32'h4);
		repeat (20) @(posedge clk_sys_i);
		bus(1'b1, ad(0, OFF_COUNT), 32'h0, q);
		`CHK("counting", 1'b1, q != 32'h0)
		wr(ad(0, OFF_CTRL), 32'h2);
		bus(1'b1, ad(0, OFF_STAT), 32'h0, q);
		`CHK("enabled", 1'b0, q[16])
		bus(1'b1, ad(0, OFF_COUNT), 32'h0, q1);
		repeat (10) @(posedge clk_sys_i);
		rdc(ad(0, OFF_COUNT), q1);
		wr(ad(0, OFF_CTRL), 32'h4);
		rdc(ad(0, OFF_COUNT), 32'h0);
		// Block-wide trigger
		for (int c = 0; c < 3; c++) begin
			wr(ad(c, OFF_MODE), 32'h0);
			wr(ad(c, OFF_CTRL), 32'h1);
		end
		wr(OFF_BCTRL, 32'h0);
		repeat (20) @(posedge clk_sys_i);
		rdc(ad(1, OFF_COUNT), 32'h0);
		wr(OFF_BCTRL, 32'h1);
		repeat (20) @(posedge clk_sys_i);
		for (int c = 0; c < 3; c++) begin
			bus(1'b1, ad(c, OFF_COUNT), 32'h0, q);
			`CHK("sync count", 1'b1, q != 32'h0)
		end
		// Aux line 0 source selection on channel 2
		ext_run <= 1'b1;
		wr(ad(2, OFF_MODE), 32'h5);
		wr(OFF_BMODE, 32'h1);
		wr(ad(2, OFF_CTRL), 32'h4);
		repeat (40) @(posedge clk_sys_i);
		rdc(ad(2, OFF_COUNT), 32'h0);
		wr(OFF_BMODE, 32'h0);
		repeat (40) @(posedge clk_sys_i);
		bus(1'b1, ad(2, OFF_COUNT), 32'h0, q);
		`CHK("aux count", 1'b1, q != 32'h0)
		// Software trigger actions on both lines of channel 1
		foreach (ACT[i]) begin
			wr(ad(1, OFF_MODE), 32'h8400 | (32'(ACT[i]) << 22) | (32'(ACT[i]) << 30));
			wr(ad(1, OFF_CTRL), 32'h4);
			repeat (2) @(posedge clk_sys_i);
			@(negedge clk_sys_i);
			`CHK("line a", LVL[i], io_line_a_o[1])
			`CHK("line b", LVL[i], io_line_b_o[1])
			`CHK("oe", 2'b11, {io_line_a_oe_o[1], io_line_b_oe_o[1]})
		end
		stop_test();
	end
endmodule
`undef CHK
`default_nettype wire

// >>> verif/timer_pins_model.sv
// Far side of the timer: internal ticks, external clocks, pin levels.
// Assumes one clock; a driven pin reads back what the block drives.
`default_nettype none
module timer_pins_model
	import timer_pkg::*;
(
	// Clock and control
	input wire logic clk_sys_i,
	input wire logic ext_run_i,
	// Block side
	input wire logic [timer_pkg::NUM_CH-1:0] a_o_i,
	input wire logic [timer_pkg::NUM_CH-1:0] a_oe_i,
	input wire logic [timer_pkg::NUM_CH-1:0] b_o_i,
	input wire logic [timer_pkg::NUM_CH-1:0] b_oe_i,
	// Levels
	output logic [4:0] tick_o,
	output logic [timer_pkg::NUM_CH-1:0] ext_o,
	output logic [timer_pkg::NUM_CH-1:0] a_o,
	output logic [timer_pkg::NUM_CH-1:0] b_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00;
	always @(posedge clk_sys_i) cnt <= cnt + 8'h01;
	assign tick_o = cnt[5:1];
	// External clocks stand still unless asked to run
	assign ext_o = ext_run_i ? {3{cnt[2]}} : 3'h0;
	assign a_o = (a_oe_i & a_o_i) | (~a_oe_i & {3{cnt[6]}});
	assign b_o = (b_oe_i & b_o_i) | (~b_oe_i & {3{cnt[7]}});
endmodule
`default_nettype wire
